// *** rtl/rtcg_pkg.sv ***
package rtcg_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register indices; the byte address on apb is four times the index
	localparam logic [15:0] IDX_CLC   = 16'hf0c8; // clock gate control
	localparam logic [15:0] IDX_RELL  = 16'hf0cc; // rtc reload low
	localparam logic [15:0] IDX_RELH  = 16'hf0ce; // rtc reload high
	localparam logic [15:0] IDX_PREL  = 16'hf0d0; // prescale timer reload
	localparam logic [15:0] IDX_PCNT  = 16'hf0d2; // prescale timer count
	localparam logic [15:0] IDX_CNTL  = 16'hf0d4; // rtc count low
	localparam logic [15:0] IDX_CNTH  = 16'hf0d6; // rtc count high
	localparam logic [15:0] IDX_ISNC  = 16'hf1c8; // interrupt sub-node
	localparam logic [15:0] IDX_CON   = 16'hf1cc; // run control

	localparam int unsigned ADDR_W = 18; // byte address width
	localparam int unsigned DATA_W = 32; // apb data width
	localparam int unsigned REG_W  = 16; // register width

	////////////////////////////////////////////////////////////////////////////
	// clock gate control fields
	localparam int unsigned CLC_LOCAL = 0; // local_kernel_off_request
	localparam int unsigned CLC_STAT  = 1; // kernel_off_status
	localparam int unsigned CLC_SUSP  = 2; // debug_suspend_enable
	localparam int unsigned CLC_EXTG  = 3; // external_off_gate
	localparam logic [15:0] CLC_RST   = 16'h0000;

	// run control fields
	localparam int unsigned CON_RUN   = 0;  // count_run
	localparam int unsigned CON_PRE   = 1;  // input_prescaler_on
	localparam int unsigned CON_DEC   = 2;  // prescale_timer_step_down
	localparam int unsigned CON_INC   = 3;  // prescale_timer_step_up
	localparam int unsigned CON_ACC   = 15; // sync_access_ok
	localparam logic [15:0] CON_RST   = 16'h0003;

	// interrupt sub-node: enable at even bit, pending at odd bit
	localparam int unsigned ISNC_W    = 10;
	localparam int unsigned NSRC      = 4; // further sources beside overflow
	localparam logic [9:0]  ISNC_RST  = 10'h000;

	// input prescaler division factor
	localparam int unsigned PRE_DIV_DEF = 8;

	////////////////////////////////////////////////////////////////////////////
	// apb request from the master
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} rtcg_apb_req_t;

endpackage : rtcg_pkg

// *** rtl/rtcg_ctrl_regs.sv ***
// Notes on behaviour
// R1 - central or local off request disables kernel
// R2 - kernel runs only when both requests clear
// R3 - off request sets status, gates kernel clock
// R4 - bus and clock control stay alive when off
// R5 - while off, only clock control accepts writes
// R6 - clock control layout, upper bits zero, reset zero
// R7 - external off request honoured when gate bit 0
// R8 - suspend enable lets debug freeze the kernel
// R9 - run bit stops or runs counting
// R10 - prescaler bit inserts divider into count path
// R11 - step down bit decrements timer, self clears
// R12 - step up bit increments timer, self clears
// R13 - access bit one when sync access possible
// R14 - clock control always readable and writable
// R15 - reset sets run and prescaler bits
// R16 - timer overflow gives count pulse and event
// R17 - sub-node holds five enable/pending pairs
// R18 - pending set by hardware, set beats write
// R19 - enable bit zero blocks its source
// R20 - software clears pending flags itself
// R21 - enabled pending sources merge to one request
// R22 - status clears, clock resumes when request ends
//
// Register access over APB was left to the implementer.
module rtcg_ctrl_regs
	import rtcg_pkg::*;
#(
	parameter int unsigned PRE_DIV = PRE_DIV_DEF // input prescaler factor
)(
	// clock, reset, enable
	input  wire logic          i_clk_sys,
	input  wire logic          i_rst_n,
	input  wire logic          i_clk_en,
	// apb slave
	input  wire rtcg_apb_req_t i_apb,
	output logic [DATA_W-1:0]  o_prdata,
	output logic               o_pready,
	output logic               o_pslverr,
	// system and debug requests
	input  wire logic          i_central_kernel_off_request,
	input  wire logic          i_ext_off_request,
	input  wire logic          i_debug_suspend,
	// count input and interrupt sources
	input  wire logic          i_ref_tick,
	input  wire logic [NSRC-1:0] i_src_event,
	// kernel and interrupt outputs
	output logic               o_kernel_clk_en,
	output logic               o_kernel_off_status,
	output logic               o_count_pulse,
	output logic               o_irq
);

	localparam int unsigned PRE_W = (PRE_DIV > 1) ? $clog2(PRE_DIV) : 1;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_DIV - 1);

	////////////////////////////////////////////////////////////////////////////
	// all state of the block
	typedef struct packed {
		logic [2:0]        ext_sync;   // external off request synchroniser
		logic              ext_lvl;    // filtered external request
		logic [2:0]        tick_sync;  // count input synchroniser
		logic              tick_lvl;   // filtered count input
		logic              clc_local;  // local off request
		logic              clc_stat;   // off status
		logic              clc_susp;   // debug suspend enable
		logic              clc_extg;   // external off gate
		logic              con_run;    // run bit
		logic              con_pre;    // prescaler on
		logic              con_dec;    // pending step down
		logic              con_inc;    // pending step up
		logic [ISNC_W-1:0] isnc;       // sub-node enables and pendings
		logic [REG_W-1:0]  prel;       // prescale timer reload
		logic [REG_W-1:0]  pcnt;       // prescale timer count
		logic [3:0][REG_W-1:0] aux;    // rtc reload and count words
		logic [PRE_W-1:0]  pre_cnt;    // input prescaler count
		logic              kclk_en;    // kernel clock gate enable
		logic              cnt_pulse;  // count input to main counter
		logic              irq;        // merged interrupt request
		logic              pready;     // apb answer
		logic              pslverr;    // apb error
		logic [DATA_W-1:0] prdata;     // apb read data
	} rtcg_state_t;

	rtcg_state_t st_ff;   // registered state
	rtcg_state_t nxt_st;  // next state

	// decoded conditions; setup, commit, wr_ok and ovf are read by the assertions as well
	logic eff_off;   // effective kernel off request
	logic setup;     // apb setup cycle
	logic commit;    // apb access completes at this edge
	logic wr_ok;     // write accepted at this edge
	logic tick_rise; // filtered rising edge of count input
	logic irq_any;   // some enabled source pending
	logic ovf;       // prescale timer overflow this cycle

	////////////////////////////////////////////////////////////////////////////
	// byte address of a register index
	function automatic logic [ADDR_W-1:0] badr(input logic [15:0] idx);
		badr = {idx, 2'b00};
	endfunction : badr

	// true when the address names rtc word k of the four
	function automatic logic aux_hit(input logic [ADDR_W-1:0] a, input int k);
		logic [15:0] idx;
		idx = (k == 0) ? IDX_RELL : (k == 1) ? IDX_RELH :
		      (k == 2) ? IDX_CNTL : IDX_CNTH;
		aux_hit = (a == badr(idx));
	endfunction : aux_hit

	// read word of a register; bit 16 tells if mapped
	function automatic logic [16:0] rd_word(input logic [ADDR_W-1:0] a,
	                                        input rtcg_state_t s);
		rd_word = '0;
		if (a == badr(IDX_CLC))
		begin
			// bits 15..4 read zero
			rd_word = {1'b1, 12'h000, s.clc_extg, s.clc_susp, s.clc_stat,
			           s.clc_local}; // R6 R14
		end
		else if (a == badr(IDX_CON))
		begin
			// access bit: synchronous access only while off status is clear, debug freeze ignored
			rd_word = {1'b1, ~s.clc_stat, 11'h000, s.con_inc, s.con_dec,
			           s.con_pre, s.con_run}; // R13
		end
		else if (a == badr(IDX_ISNC))
		begin
			rd_word = {1'b1, 6'h00, s.isnc}; // R17
		end
		else if (a == badr(IDX_PREL))
		begin
			rd_word = {1'b1, s.prel};
		end
		else if (a == badr(IDX_PCNT))
		begin
			rd_word = {1'b1, s.pcnt};
		end
		else
		begin
			for (int k = 0; k < 4; k++)
			begin
				if (aux_hit(a, k))
				begin
					rd_word = {1'b1, s.aux[k]};
				end
			end
		end
	endfunction : rd_word

	////////////////////////////////////////////////////////////////////////////
	// next state logic
	always_comb
	begin
		logic [16:0] rw;   // decoded read word
		logic        mapped;
		logic [REG_W-1:0] wd; // low half of write data
		rw     = '0;
		mapped = 1'b0;
		wd     = i_apb.pwdata[REG_W-1:0];
		nxt_st = st_ff;
		ovf    = 1'b0;

		// pins pass three flops; level moves when last two agree
		nxt_st.ext_sync  = {st_ff.ext_sync[1:0], i_ext_off_request};
		nxt_st.tick_sync = {st_ff.tick_sync[1:0], i_ref_tick};
		if (st_ff.ext_sync[2] == st_ff.ext_sync[1])
		begin
			nxt_st.ext_lvl = st_ff.ext_sync[2];
		end
		if (st_ff.tick_sync[2] == st_ff.tick_sync[1])
		begin
			nxt_st.tick_lvl = st_ff.tick_sync[2];
		end
		tick_rise = (st_ff.tick_sync[2] == st_ff.tick_sync[1]) &&
		            st_ff.tick_sync[2] && !st_ff.tick_lvl;

		// ored off requests; external one only when gate bit is zero
		eff_off = i_central_kernel_off_request | st_ff.clc_local |
		          (st_ff.ext_lvl & ~st_ff.clc_extg); // R1 R2 R7
		nxt_st.clc_stat = eff_off; // R3 R22
		// debug may also freeze the kernel, but only if allowed
		nxt_st.kclk_en  = ~eff_off &
		                  ~(st_ff.clc_susp & i_debug_suspend); // R3 R8 R22

		// kernel logic runs only under the gated clock
		nxt_st.cnt_pulse = 1'b0;
		if (st_ff.kclk_en)
		begin
			if (st_ff.con_inc)
			begin
				nxt_st.pcnt    = st_ff.pcnt + 16'h0001; // R12
				nxt_st.con_inc = 1'b0; // R12
			end
			else if (st_ff.con_dec)
			begin
				nxt_st.pcnt    = st_ff.pcnt - 16'h0001; // R11
				nxt_st.con_dec = 1'b0; // R11
			end
			else if (st_ff.con_run && tick_rise) // R9
			begin
				// prescaler swallows ticks until its last one
				if (st_ff.con_pre && (st_ff.pre_cnt != PRE_LAST)) // R10
				begin
					nxt_st.pre_cnt = st_ff.pre_cnt + PRE_W'(1);
				end
				else
				begin
					nxt_st.pre_cnt = '0;
					if (st_ff.pcnt == 16'hffff)
					begin
						// overflow reloads and feeds the main counter
						nxt_st.pcnt      = st_ff.prel;
						nxt_st.cnt_pulse = 1'b1; // R16
						ovf              = 1'b1; // R16
					end
					else
					begin
						nxt_st.pcnt = st_ff.pcnt + 16'h0001;
					end
				end
			end
		end

		// apb: answer one cycle into the access phase
		setup  = i_apb.psel & ~i_apb.penable;
		commit = i_apb.psel & i_apb.penable & st_ff.pready;
		nxt_st.pready = i_apb.psel & i_apb.penable & ~st_ff.pready;
		rw     = rd_word(i_apb.paddr, st_ff);
		mapped = rw[16];
		if (setup)
		begin
			// refused writes and holes answer with an error
			nxt_st.prdata  = {16'h0000, rw[15:0]};
			nxt_st.pslverr = ~mapped | (i_apb.pwrite & st_ff.clc_stat &
			                 (i_apb.paddr != badr(IDX_CLC))); // R5
		end
		// clock control takes writes even when off
		wr_ok = commit & i_apb.pwrite & mapped &
		        (~st_ff.clc_stat | (i_apb.paddr == badr(IDX_CLC))); // R4 R5 R14

		// bus writes come after the kernel so the bus wins on the timer
		if (wr_ok)
		begin
			if (i_apb.paddr == badr(IDX_CLC))
			begin
				nxt_st.clc_local = wd[CLC_LOCAL]; // R6
				nxt_st.clc_susp  = wd[CLC_SUSP]; // R6
				nxt_st.clc_extg  = wd[CLC_EXTG]; // R6
			end
			else if (i_apb.paddr == badr(IDX_CON))
			begin
				nxt_st.con_run = wd[CON_RUN]; // R9
				nxt_st.con_pre = wd[CON_PRE]; // R10
				nxt_st.con_dec = wd[CON_DEC]; // R11
				nxt_st.con_inc = wd[CON_INC]; // R12
			end
			else if (i_apb.paddr == badr(IDX_ISNC))
			begin
				nxt_st.isnc = wd[ISNC_W-1:0]; // R20
			end
			else if (i_apb.paddr == badr(IDX_PREL))
			begin
				nxt_st.prel = wd;
			end
			else if (i_apb.paddr == badr(IDX_PCNT))
			begin
				nxt_st.pcnt = wd;
			end
			else
			begin
				for (int k = 0; k < 4; k++)
				begin
					if (aux_hit(i_apb.paddr, k))
					begin
						nxt_st.aux[k] = wd;
					end
				end
			end
		end

		// hardware sets after the write, so a set is never lost
		nxt_st.isnc[1] = nxt_st.isnc[1] | ovf; // R18
		for (int k = 0; k < NSRC; k++)
		begin
			nxt_st.isnc[2*k+3] = nxt_st.isnc[2*k+3] | i_src_event[k]; // R18
		end

		// merge enabled pendings into one node request
		irq_any = 1'b0;
		for (int k = 0; k <= NSRC; k++)
		begin
			irq_any = irq_any | (st_ff.isnc[2*k] & st_ff.isnc[2*k+1]); // R19 R21
		end
		nxt_st.irq = irq_any; // R21
	end

	////////////////////////////////////////////////////////////////////////////
	// state register; low clock enable freezes everything
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_ff           <= '0;
			st_ff.clc_local <= CLC_RST[CLC_LOCAL]; // R6
			st_ff.con_run   <= CON_RST[CON_RUN]; // R15
			st_ff.con_pre   <= CON_RST[CON_PRE]; // R15
			st_ff.isnc      <= ISNC_RST;
		end
		else if (i_clk_en)
		begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flops
	assign o_prdata            = st_ff.prdata;
	assign o_pready            = st_ff.pready;
	assign o_pslverr           = st_ff.pslverr;
	assign o_kernel_clk_en     = st_ff.kclk_en;
	assign o_kernel_off_status = st_ff.clc_stat;
	assign o_count_pulse       = st_ff.cnt_pulse;
	assign o_irq               = st_ff.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_local_off;
		i_clk_en && st_ff.clc_local;
	endsequence

	property p_local_or;
		s_local_off |=> st_ff.clc_stat && !o_kernel_clk_en;
	endproperty
	a_local_or: assert property (p_local_or) else $error("local off ignored"); // R1

	property p_central;
		i_clk_en && i_central_kernel_off_request |=> o_kernel_off_status;
	endproperty
	a_central: assert property (p_central) else $error("central off ignored"); // R3

	property p_resume;
		i_clk_en && !i_central_kernel_off_request && !st_ff.clc_local &&
		!(st_ff.ext_lvl && !st_ff.clc_extg) |=> !st_ff.clc_stat;
	endproperty
	a_resume: assert property (p_resume) else $error("status stuck"); // R22

	property p_ext_gate;
		i_clk_en && st_ff.ext_lvl && !st_ff.clc_extg |=> st_ff.clc_stat;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("external off lost"); // R7

	property p_refuse;
		i_clk_en && commit && i_apb.pwrite && st_ff.clc_stat &&
		i_apb.paddr == badr(IDX_PREL) |=> $stable(st_ff.prel);
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken while off"); // R5

	sequence s_step_down;
		i_clk_en && st_ff.kclk_en && st_ff.con_dec && !st_ff.con_inc && !wr_ok;
	endsequence

	property p_step_down;
		s_step_down |=> (st_ff.pcnt == $past(st_ff.pcnt) - 16'h0001) &&
		                !st_ff.con_dec;
	endproperty
	a_step_down: assert property (p_step_down) else $error("step down wrong"); // R11

	property p_step_up;
		i_clk_en && st_ff.kclk_en && st_ff.con_inc && !wr_ok |=>
		(st_ff.pcnt == $past(st_ff.pcnt) + 16'h0001) && !st_ff.con_inc;
	endproperty
	a_step_up: assert property (p_step_up) else $error("step up wrong"); // R12

	property p_pend_set;
		i_clk_en && ovf |=> st_ff.isnc[1] && o_count_pulse;
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("overflow lost"); // R18

	property p_merge;
		i_clk_en |=> o_irq == $past(|(st_ff.isnc[9:1] & st_ff.isnc[8:0] & 9'h155));
	endproperty
	a_merge: assert property (p_merge) else $error("irq merge wrong"); // R21

	property p_acc_read;
		i_clk_en && setup && i_apb.paddr == badr(IDX_CON) |=>
		o_prdata[CON_ACC] == !$past(st_ff.clc_stat);
	endproperty
	a_acc_read: assert property (p_acc_read) else $error("access bit wrong"); // R13

	property p_apb_ready;
		i_clk_en && i_apb.psel && i_apb.penable && !o_pready |=> o_pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("no answer"); // R4

endmodule : rtcg_ctrl_regs

// *** verif/rtcg_ctrl_regs_tb_top.sv ***
module rtcg_ctrl_regs_tb_top
	import rtcg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// fails a compare on any difference, unknowns included
	`define CHK(got, exp) \
	begin \
		samples_checked++; \
		if ((got) !== (exp)) \
		begin \
			n_mismatch++; \
			$display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); \
		end \
	end

	////////////////////////////////////////////////////////////////////////////
	// clock, reset, design ports and bench variables
	logic          clk_sys;       // bus clock, 8 ns
	logic          rst_n;         // async reset, active low
	rtcg_apb_req_t apb_req;       // apb request from the bench
	logic [31:0]   prdata;        // read data
	logic          pready;        // apb ready
	logic          pslverr;       // apb error
	logic          central_off;   // system level off request
	logic          ext_off;       // external off pin
	logic          dbg_susp;      // debug freeze request
	logic          ref_tick;      // count input pin
	logic          clk_en;        // clock enable, low freezes the block
	logic [NSRC-1:0] src_event;   // further interrupt sources
	logic          kclk_en;       // kernel clock gate
	logic          off_status;    // off status level
	logic          count_pulse;   // overflow pulse
	logic          irq;           // merged request
	int            n_mismatch;      // failed compares
	int            samples_checked; // compares made
	int            n_pulse;         // overflow pulses seen
	logic [31:0]   rdata;           // last read data
	logic          perr;            // last error flag

	////////////////////////////////////////////////////////////////////////////
	// short prescaler keeps the tick scenarios quick
	rtcg_ctrl_regs #(
		.PRE_DIV(2)
	) uut (
		.i_clk_sys                    (clk_sys),
		.i_rst_n                      (rst_n),
		.i_clk_en                     (clk_en),
		.i_apb                        (apb_req),
		.o_prdata                     (prdata),
		.o_pready                     (pready),
		.o_pslverr                    (pslverr),
		.i_central_kernel_off_request (central_off),
		.i_ext_off_request            (ext_off),
		.i_debug_suspend              (dbg_susp),
		.i_ref_tick                   (ref_tick),
		.i_src_event                  (src_event),
		.o_kernel_clk_en              (kclk_en),
		.o_kernel_off_status          (off_status),
		.o_count_pulse                (count_pulse),
		.o_irq                        (irq)
	);

	// free running clock
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// overflow pulses are counted as they pass, they last one cycle only
	always @(posedge clk_sys)
	begin
		if (count_pulse === 1'b1)
			n_pulse++;
	end

	////////////////////////////////////////////////////////////////////////////
	// counts, verdict and end of run
	task automatic final_report();
		$display("compares %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		apb_req.psel    <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite  <= wr;
		apb_req.paddr   <= {idx, 2'b00};
		apb_req.pwdata  <= {16'h0000, d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		// bounded wait: a missing ready must not hang the run
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdata = prdata;
		perr  = pslverr;
		apb_req.psel    <= 1'b0;
		apb_req.penable <= 1'b0;
		if (n >= 20)
			`CHK(pready, 1'b1)
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	// read and compare the whole word, upper half must be zero
	task automatic rd_chk(input logic [15:0] idx, input logic [15:0] exp);
		apb(1'b0, idx, 16'h0000);
		`CHK(rdata, {16'h0000, exp})
	endtask : rd_chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	// slow pin ticks, wide enough for the input synchroniser
	task automatic tick(input int n);
		repeat (n)
		begin
			ref_tick <= 1'b1;
			cyc(4);
			ref_tick <= 1'b0;
			cyc(4);
		end
		cyc(4);
	endtask : tick

	// watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#(8 * 20000);
		n_mismatch++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		rst_n       = 1'b0;
		apb_req     = '0;
		central_off = 1'b0;
		ext_off     = 1'b0;
		dbg_susp    = 1'b0;
		ref_tick    = 1'b0;
		clk_en      = 1'b1;
		src_event   = '0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd_chk(IDX_CLC, 16'h0000);
		rd_chk(IDX_CON, 16'h8003);
		`CHK(kclk_en, 1'b1)
		$display("test reset values done");
		// prescaler inserted: two ticks per timer step
		wr(IDX_PCNT, 16'h0010);
		tick(4);
		rd_chk(IDX_PCNT, 16'h0012);
		wr(IDX_CON, 16'h0000);
		tick(2);
		rd_chk(IDX_PCNT, 16'h0012);
		wr(IDX_CON, 16'h0008);
		cyc(3);
		rd_chk(IDX_PCNT, 16'h0013);
		rd_chk(IDX_CON, 16'h8000);
		wr(IDX_CON, 16'h0004);
		cyc(3);
		rd_chk(IDX_PCNT, 16'h0012);
		$display("test timer steps done");
		// overflow without prescaler reloads and raises the pending flag
		wr(IDX_PREL, 16'h0100);
		wr(IDX_PCNT, 16'hfffe);
		wr(IDX_CON, 16'h0001);
		tick(2);
		rd_chk(IDX_PCNT, 16'h0100);
		`CHK(n_pulse, 1)
		rd_chk(IDX_ISNC, 16'h0002);
		`CHK(irq, 1'b0)
		wr(IDX_ISNC, 16'h0003);
		cyc(3);
		`CHK(irq, 1'b1)
		wr(IDX_ISNC, 16'h0001);
		cyc(3);
		`CHK(irq, 1'b0)
		rd_chk(IDX_ISNC, 16'h0001);
		// each further source lands on its own pending bit
		wr(IDX_ISNC, 16'h0155);
		for (int k = 0; k < 4; k++)
		begin
			src_event <= 4'(1 << k);
			cyc(1);
			src_event <= '0;
			cyc(3);
			rd_chk(IDX_ISNC, 16'h0155 | (16'h0008 << (2 * k)));
			`CHK(irq, 1'b1)
			wr(IDX_ISNC, 16'h0155);
		end
		// unused upper bits of the sub-node read back as zero
		wr(IDX_ISNC, 16'hffff);
		rd_chk(IDX_ISNC, 16'h03ff);
		wr(IDX_ISNC, 16'h0000);
		$display("test interrupts done");
		// local off: status, gate, refused writes, clock control still open
		wr(IDX_CLC, 16'h0001);
		cyc(2);
		`CHK(off_status, 1'b1)
		`CHK(kclk_en, 1'b0)
		rd_chk(IDX_CLC, 16'h0003);
		rd_chk(IDX_CON, 16'h0001);
		wr(IDX_PREL, 16'h00aa);
		`CHK(perr, 1'b1)
		rd_chk(IDX_PREL, 16'h0100);
		wr(IDX_CON, 16'h0000);
		rd_chk(IDX_CON, 16'h0001);
		wr(IDX_CLC, 16'hffff);
		`CHK(perr, 1'b0)
		rd_chk(IDX_CLC, 16'h000f);
		// central request alone keeps the kernel off
		central_off <= 1'b1;
		wr(IDX_CLC, 16'h0000);
		cyc(2);
		`CHK(off_status, 1'b1)
		central_off <= 1'b0;
		cyc(2);
		`CHK(off_status, 1'b0)
		`CHK(kclk_en, 1'b1)
		// external pin, honoured then masked by the gate bit
		ext_off <= 1'b1;
		cyc(8);
		`CHK(off_status, 1'b1)
		wr(IDX_CLC, 16'h0008);
		cyc(2);
		`CHK(off_status, 1'b0)
		ext_off <= 1'b0;
		wr(IDX_CLC, 16'h0000);
		// debug freeze only when suspend is enabled
		dbg_susp <= 1'b1;
		cyc(2);
		`CHK(kclk_en, 1'b1)
		wr(IDX_CLC, 16'h0004);
		cyc(2);
		`CHK(kclk_en, 1'b0)
		`CHK(off_status, 1'b0)
		dbg_susp <= 1'b0;
		// low clock enable freezes the status even with a request pending
		clk_en      <= 1'b0;
		central_off <= 1'b1;
		cyc(3);
		`CHK(off_status, 1'b0)
		clk_en      <= 1'b1;
		cyc(2);
		`CHK(off_status, 1'b1)
		central_off <= 1'b0;
		cyc(2);
		$display("test off control done");
		// unmapped word answers with an error and zero data
		apb(1'b0, 16'h0001, 16'h0000);
		`CHK(perr, 1'b1)
		`CHK(rdata, 32'h0000_0000)
		$display("test unmapped done");
		final_report();
	end

endmodule : rtcg_ctrl_regs_tb_top
